// ### core/tprot_defines.svh
// Purpose: shared constants of the temperature and host silence protection
// Assumes: one 100 MHz clock
// Notes:   indices select the five temperature protections
`ifndef TPROT_DEFINES_SVH
`define TPROT_DEFINES_SVH
`define TPROT_CLK_NS      10
`define TPROT_SEC_NS      1000000000
`define TPROT_NPROT       5
`define TPROT_NSENS       4
`define TPROT_TW          9
`define TPROT_FET_HOT     0
`define TPROT_DIE_HOT     1
`define TPROT_CHG_COLD    2
`define TPROT_DSG_COLD    3
`define TPROT_DIE_COLD    4
`define TPROT_OVER_MASK   5'h03
`define TPROT_ALWAYS_REC  5'h0C
`define TPROT_REG_KEEP    2'h0
`define TPROT_REG_OFF     2'h1
`define TPROT_REG_TOGGLE  2'h2
`define TPROT_TEMP_LOW    9'h100
`define TPROT_TEMP_HIGH   9'h0FF
`endif

// ### core/tprot_pkg.sv
// Purpose: types of the temperature and host silence protection
// Assumes: temperatures are signed whole degrees
// Notes:   one configuration record per temperature protection
package tprot_pkg;
  typedef logic signed [8:0] tprot_temp_type;
  typedef struct packed {
    logic           enable;
    tprot_temp_type threshold;
    tprot_temp_type recovery;
    logic [7:0]     delay;
    logic           charge_sel;
    logic           discharge_sel;
  } tprot_cfg_type;
  typedef struct packed {
    logic        enable;
    logic [15:0] host_silence_delay;
    logic        charge_sel;
    logic        discharge_sel;
    logic [1:0]  reg_option;
    logic [3:0]  toggle_secs;
  } tprot_wd_cfg_type;
  typedef enum logic [1:0] {TPROT_REG_IDLE, TPROT_REG_HELD, TPROT_REG_WAIT} tprot_reg_state_type;
endpackage

// ### core/tprot_top.sv
// Purpose: temperature and host silence protection with alert, fault and recovery
// Assumes: temperature inputs synchronous to i_clock, sensor 0 is the die sensor
// Notes:   all delays count whole seconds from a free divider tick
// Overview of operation
// - fet_overtemp trips when fet temperature is at or above fet_hot_threshold.
// - fet_overtemp alerts first, faults after fet_hot_delay seconds.
// - fet_overtemp fault turns off selected charge and discharge switches when autonomous.
// - fet temperature is the maximum of enabled sensors assigned to fet.
// - with autonomous recovery, fault clears after temperature holds at recovery for recovery time.
// - die_overtemp trips when die temperature is at or above die_hot_threshold.
// - die_overtemp alerts first, faults after die_hot_delay seconds.
// - die_overtemp fault turns off selected switches when autonomous.
// - charge_undertemp trips when cell temperature is at or below charge_cold_threshold.
// - charge_undertemp alerts first, faults after charge_cold_delay seconds.
// - charge_undertemp fault turns off charge_switch if selected; recovers after recovery time.
// - cell temperature is the minimum of enabled sensors assigned to cell.
// - discharge_undertemp trips at or below threshold, alerting then faulting after delay.
// - discharge_undertemp fault turns off discharge switch if selected; recovers after time.
// - die_undertemp trips at or below die_cold_threshold, alerting then faulting after delay.
// - die_undertemp fault turns off selected switches; with autonomous recovery, recovers after recovery time.
// - host_silence_fault rises after host_silence_delay seconds without communication.
// - host silence fault turns off selected switches; with autonomous recovery, valid communication recovers it.
// - host silence guard has no alert, only a status bit.
// - regulator option keeps, disables, or disables then re-enables both regulators.
// - after the toggle delay regulators return to their configured enables.
// - each protection is gated by its own enable bit.
`timescale 1ns/1ns
`include "tprot_defines.svh"
module tprot_top #(
  parameter int unsigned TICK_CYCLES = `TPROT_SEC_NS / `TPROT_CLK_NS
) (
  input  wire logic                                        i_clock,
  input  wire logic                                        i_arst_n,
  input  wire tprot_pkg::tprot_temp_type [`TPROT_NSENS-1:0] i_sensor_temp,
  input  wire logic [`TPROT_NSENS-1:0]                     i_sensor_enable,
  input  wire logic [`TPROT_NSENS-1:0]                     i_fet_assign,
  input  wire logic [`TPROT_NSENS-1:0]                     i_cell_assign,
  input  wire tprot_pkg::tprot_cfg_type [`TPROT_NPROT-1:0]  i_cfg,
  input  wire tprot_pkg::tprot_wd_cfg_type                 i_wd_cfg,
  input  wire logic [7:0]                                  i_recovery_time,
  input  wire logic                                        i_auto_fet,
  input  wire logic                                        i_auto_recover,
  input  wire logic                                        i_host_comm,
  input  wire logic                                        i_ldo_one_enable,
  input  wire logic                                        i_ldo_two_enable,
  output logic [`TPROT_NPROT-1:0]                          o_alert,
  output logic [`TPROT_NPROT-1:0]                          o_fault,
  output logic                                             o_host_silence_fault,
  output logic                                             o_charge_switch_off,
  output logic                                             o_discharge_switch_off,
  output logic                                             o_ldo_one_enable,
  output logic                                             o_ldo_two_enable
);
  import tprot_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // highest enabled reading among the selected sensors
  function automatic tprot_temp_type pick_max(input tprot_temp_type [`TPROT_NSENS-1:0] t,
                                              input logic [`TPROT_NSENS-1:0] sel);
    tprot_temp_type m;
    m = `TPROT_TEMP_LOW;
    for (int s = 0; s < `TPROT_NSENS; s++) begin
      if (sel[s] && (t[s] > m)) m = t[s];
    end
    return m;
  endfunction

  // lowest enabled reading among the selected sensors
  function automatic tprot_temp_type pick_min(input tprot_temp_type [`TPROT_NSENS-1:0] t,
                                              input logic [`TPROT_NSENS-1:0] sel);
    tprot_temp_type m;
    m = `TPROT_TEMP_HIGH;
    for (int s = 0; s < `TPROT_NSENS; s++) begin
      if (sel[s] && (t[s] < m)) m = t[s];
    end
    return m;
  endfunction

  // one second tick from the divider
  logic [31:0] div_count;
  logic        tick;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_count <= 32'h0000_0000;
      tick      <= 1'b0;
    end else begin
      tick      <= (div_count == TICK_LAST);
      div_count <= (div_count == TICK_LAST) ? 32'h0000_0000 : div_count + 32'h0000_0001;
    end
  end

  // temperature selection per protection
  tprot_temp_type                     fet_temp;
  tprot_temp_type                     cell_temp;
  tprot_temp_type [`TPROT_NPROT-1:0]  prot_temp;
  assign fet_temp  = pick_max(i_sensor_temp, i_sensor_enable & i_fet_assign);
  assign cell_temp = pick_min(i_sensor_temp, i_sensor_enable & i_cell_assign);
  assign prot_temp[`TPROT_FET_HOT]  = fet_temp;
  assign prot_temp[`TPROT_DIE_HOT]  = i_sensor_temp[0];
  assign prot_temp[`TPROT_CHG_COLD] = cell_temp;
  assign prot_temp[`TPROT_DSG_COLD] = cell_temp;
  assign prot_temp[`TPROT_DIE_COLD] = i_sensor_temp[0];

  // trip and recovery comparisons, hot ones upward, cold ones downward
  logic [`TPROT_NPROT-1:0] trip;
  logic [`TPROT_NPROT-1:0] back;
  logic [`TPROT_NPROT-1:0] may_recover;
  logic [7:0]              det_count [`TPROT_NPROT];
  logic [7:0]              rec_count [`TPROT_NPROT];
  genvar k;
  for (k = 0; k < `TPROT_NPROT; k++) begin : g_cmp
    localparam logic OVER = 1'(`TPROT_OVER_MASK >> k);
    assign trip[k] = OVER ? (prot_temp[k] >= i_cfg[k].threshold)
                          : (prot_temp[k] <= i_cfg[k].threshold);
    assign back[k] = OVER ? (prot_temp[k] <= i_cfg[k].recovery)
                          : (prot_temp[k] >= i_cfg[k].recovery);
    assign may_recover[k] = i_auto_recover | 1'(`TPROT_ALWAYS_REC >> k);
  end

  // alert, delayed fault and timed recovery for each temperature protection
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alert <= '0;
      o_fault <= '0;
      for (int p = 0; p < `TPROT_NPROT; p++) begin
        det_count[p] <= 8'h00;
        rec_count[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < `TPROT_NPROT; p++) begin
        if (!i_cfg[p].enable) begin
          o_alert[p]   <= 1'b0;
          o_fault[p]   <= 1'b0;
          det_count[p] <= 8'h00;
          rec_count[p] <= 8'h00;
        end else if (!o_fault[p]) begin
          rec_count[p] <= 8'h00;
          if (!trip[p]) begin
            o_alert[p]   <= 1'b0;
            det_count[p] <= 8'h00;
          end else if (det_count[p] >= i_cfg[p].delay) begin
            o_alert[p]   <= 1'b0;
            o_fault[p]   <= 1'b1;
            det_count[p] <= 8'h00;
          end else begin
            o_alert[p] <= 1'b1;
            if (tick) det_count[p] <= det_count[p] + 8'h01;
          end
        end else if (may_recover[p] && back[p]) begin
          if (rec_count[p] >= i_recovery_time) begin
            o_fault[p]   <= 1'b0;
            rec_count[p] <= 8'h00;
          end else if (tick) begin
            rec_count[p] <= rec_count[p] + 8'h01;
          end
        end else begin
          rec_count[p] <= 8'h00;
        end
      end
    end
  end

  // host silence counter, restarted by every valid communication
  logic [15:0] silence_count;
  logic        wd_set;
  assign wd_set = i_wd_cfg.enable && !o_host_silence_fault && !i_host_comm
                  && (silence_count >= i_wd_cfg.host_silence_delay);
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      silence_count        <= 16'h0000;
      o_host_silence_fault <= 1'b0;
    end else begin
      if (i_host_comm || !i_wd_cfg.enable) silence_count <= 16'h0000;
      else if (tick && silence_count != 16'hFFFF) silence_count <= silence_count + 16'h0001;
      if (!i_wd_cfg.enable) o_host_silence_fault <= 1'b0;
      else if (wd_set) o_host_silence_fault <= 1'b1;
      else if (i_host_comm && i_auto_recover) o_host_silence_fault <= 1'b0;
    end
  end

  // switch requests from every fault under autonomous control
  logic [`TPROT_NPROT-1:0] chg_sel;
  logic [`TPROT_NPROT-1:0] dsg_sel;
  logic                    next_chg_off;
  logic                    next_dsg_off;
  // the charge and discharge cold protections reach only their own switch
  for (k = 0; k < `TPROT_NPROT; k++) begin : g_sel
    localparam logic CHG_REACH = (k != `TPROT_DSG_COLD);
    localparam logic DSG_REACH = (k != `TPROT_CHG_COLD);
    assign chg_sel[k] = i_cfg[k].charge_sel & CHG_REACH;
    assign dsg_sel[k] = i_cfg[k].discharge_sel & DSG_REACH;
  end
  assign next_chg_off = i_auto_fet && ((|(o_fault & chg_sel))
                        || (o_host_silence_fault && i_wd_cfg.charge_sel));
  assign next_dsg_off = i_auto_fet && ((|(o_fault & dsg_sel))
                        || (o_host_silence_fault && i_wd_cfg.discharge_sel));
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_charge_switch_off    <= 1'b0;
      o_discharge_switch_off <= 1'b0;
    end else begin
      o_charge_switch_off    <= next_chg_off;
      o_discharge_switch_off <= next_dsg_off;
    end
  end

  // regulator handling after a host silence fault
  tprot_reg_state_type reg_state;
  logic [3:0]          toggle_count;
  logic                reg_off;
  assign reg_off = (reg_state != TPROT_REG_IDLE);
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reg_state    <= TPROT_REG_IDLE;
      toggle_count <= 4'h0;
    end else begin
      case (reg_state)
        TPROT_REG_IDLE: begin
          toggle_count <= 4'h0;
          if (wd_set && i_wd_cfg.reg_option == `TPROT_REG_OFF) reg_state <= TPROT_REG_HELD;
          if (wd_set && i_wd_cfg.reg_option == `TPROT_REG_TOGGLE) reg_state <= TPROT_REG_WAIT;
        end
        TPROT_REG_HELD: reg_state <= TPROT_REG_HELD;
        TPROT_REG_WAIT: begin
          if (toggle_count >= i_wd_cfg.toggle_secs) reg_state <= TPROT_REG_IDLE;
          else if (tick) toggle_count <= toggle_count + 4'h1;
        end
        default: reg_state <= TPROT_REG_IDLE;
      endcase
    end
  end

  // regulators follow their configured enables unless held off
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ldo_one_enable <= 1'b0;
      o_ldo_two_enable <= 1'b0;
    end else begin
      o_ldo_one_enable <= i_ldo_one_enable && !reg_off;
      o_ldo_two_enable <= i_ldo_two_enable && !reg_off;
    end
  end

  // checks on the protection behaviour
  for (k = 0; k < `TPROT_NPROT; k++) begin : g_chk
    a_alert_on_trip: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_cfg[k].enable && trip[k] && !o_fault[k] && det_count[k] < i_cfg[k].delay |=> o_alert[k])
      else $error("alert missing on trip");
    a_alert_drop: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !o_fault[k] && !trip[k] |=> !o_alert[k] && det_count[k] == 8'h00)
      else $error("alert kept without trip");
    a_enable_gate: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !i_cfg[k].enable |=> !o_alert[k] && !o_fault[k])
      else $error("disabled protection active");
    a_fault_cause: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $rose(o_fault[k]) |-> $past(trip[k]) && $past(det_count[k] >= i_cfg[k].delay))
      else $error("fault without expired delay");
    a_fault_switch: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_fault[k] && chg_sel[k] && i_auto_fet |=> o_charge_switch_off)
      else $error("charge switch not off on fault");
    a_recover_cause: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $fell(o_fault[k]) && $past(i_cfg[k].enable) |-> $past(back[k]) && $past(may_recover[k]))
      else $error("recovery without condition");
    a_fault_dsg: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_fault[k] && dsg_sel[k] && i_auto_fet |=> o_discharge_switch_off)
      else $error("discharge switch not off on fault");
    a_manual_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_fault[k] && i_cfg[k].enable && !may_recover[k] |=> o_fault[k])
      else $error("fault cleared without recovery allowed");
  end
  a_fet_max: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_sensor_enable[1] && i_fet_assign[1] |-> fet_temp >= i_sensor_temp[1])
    else $error("fet temperature not maximum");
  a_cell_min: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_sensor_enable[1] && i_cell_assign[1] |-> cell_temp <= i_sensor_temp[1])
    else $error("cell temperature not minimum");
  a_wd_silent: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(o_host_silence_fault) |-> !$past(i_host_comm) && $past(silence_count >= i_wd_cfg.host_silence_delay))
    else $error("silence fault without silence");
  a_wd_recover: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_host_silence_fault && i_host_comm && i_auto_recover |=> !o_host_silence_fault)
    else $error("silence fault kept after communication");
  a_reg_drop: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wd_set && i_wd_cfg.reg_option != `TPROT_REG_KEEP && i_wd_cfg.reg_option != 2'h3
    |=> ##1 !o_ldo_one_enable && !o_ldo_two_enable)
    else $error("regulators not disabled");
  a_reg_restore: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $fell(reg_off) |=> o_ldo_one_enable == $past(i_ldo_one_enable))
    else $error("regulator not restored to configuration");

  // guard switch path and the indefinite regulator hold
  a_wd_switch: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_host_silence_fault && i_wd_cfg.discharge_sel && i_auto_fet |=> o_discharge_switch_off)
    else $error("discharge switch not off on silence fault");
  a_reg_held: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    reg_state == TPROT_REG_HELD |=> !o_ldo_one_enable && !o_ldo_two_enable)
    else $error("regulators on while held off");
  c_fault: cover property (@(posedge i_clock) disable iff (!i_arst_n) $rose(o_fault[0]));
  c_recover: cover property (@(posedge i_clock) disable iff (!i_arst_n) $fell(o_fault[2]));
  c_wd_fault: cover property (@(posedge i_clock) disable iff (!i_arst_n) $rose(o_host_silence_fault));
  c_toggle: cover property (@(posedge i_clock) disable iff (!i_arst_n) $fell(reg_off));
  c_cold_fault: cover property (@(posedge i_clock) disable iff (!i_arst_n) $rose(o_fault[3]));
endmodule // tprot_top

// ### tb/tprot_host_model.sv
// Purpose: host processor model that sends messages to the protection block
// Assumes: one clock; the bench sets talk and gap
// Notes:   one-cycle pulse per message, silent while talk is low
`timescale 1ns/1ns
module tprot_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_talk,
  input  wire logic [7:0] i_gap,
  output logic            o_host_comm
);
  logic [7:0] count;
  // pulse once every gap plus one cycles while talking; this traffic is what recovers the guard
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count       <= 8'h00;
      o_host_comm <= 1'b0;
    end else begin
      count       <= (count >= i_gap) ? 8'h00 : count + 8'h01;
      o_host_comm <= i_talk && (count >= i_gap);
    end
  end
endmodule // tprot_host_model

// ### tb/testbench.sv
// Purpose: self-checking bench of the temperature and host silence protection
// Assumes: short second tick of 10 cycles
// Notes:   each temperature protection runs alone; the host model drives comms
`timescale 1ns/1ns
`include "tprot_defines.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  import tprot_pkg::*;
  localparam int TICK = 10;
  logic                                  i_clock = 1'b0;
  logic                                  i_arst_n = 1'b0;
  tprot_temp_type [`TPROT_NSENS-1:0]     sensor_temp = {4{9'h019}};
  logic [3:0]                            sensor_enable = 4'hF;
  tprot_cfg_type [`TPROT_NPROT-1:0]      cfg = '0;
  tprot_wd_cfg_type                      wd_cfg = '0;
  logic                                  talk = 1'b0;
  logic                                  ldo_two = 1'b1;
  logic                                  auto_fet = 1'b1;
  logic                                  auto_recover = 1'b1;
  logic                                  host_comm;
  logic [4:0]                            alert;
  logic [4:0]                            fault;
  logic                                  host_fault;
  logic [1:0]                            sw_off;
  logic [1:0]                            ldo;
  logic [1:0]                            opt;
  int                                    err_total = 0;
  int                                    compares = 0;
  int                                    cycles = 0;
  // clock and hang guard
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_total++;
      summarize();
    end
  end
  tprot_host_model HOST (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_talk(talk), .i_gap(8'h05),
    .o_host_comm(host_comm));
  tprot_top #(.TICK_CYCLES(TICK)) DUT (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_sensor_temp(sensor_temp),
    .i_sensor_enable(sensor_enable), .i_fet_assign(4'h2), .i_cell_assign(4'hC), .i_cfg(cfg), .i_wd_cfg(wd_cfg),
    .i_recovery_time(8'h02), .i_auto_fet(auto_fet), .i_auto_recover(auto_recover), .i_host_comm(host_comm),
    .i_ldo_one_enable(1'b1), .i_ldo_two_enable(ldo_two), .o_alert(alert), .o_fault(fault),
    .o_host_silence_fault(host_fault), .o_charge_switch_off(sw_off[1]), .o_discharge_switch_off(sw_off[0]),
    .o_ldo_one_enable(ldo[1]), .o_ldo_two_enable(ldo[0]));
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  function automatic logic sig(input int s);
    return (s < 5) ? fault[s] : host_fault;
  endfunction
  task automatic wait_sig(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (sig(s) !== v && k < lim) begin
      cyc(1);
      k++;
    end
    `CHK("fault level", v, sig(s))
  endtask
  // drive the sensor that feeds protection p
  task automatic set_temp(input int p, input tprot_temp_type t);
    @(posedge i_clock);
    if (p == 0) sensor_temp[1] <= t;
    else if (p == 1 || p == 4) sensor_temp[0] <= t;
    else sensor_temp[3] <= t;
  endtask
  // one full trip, fault, switch-off and recovery pass of protection p
  task automatic run_prot(input int p, input tprot_temp_type thr, near, trip, rec, input logic [7:0] dly,
                          input logic cs, ds);
    @(posedge i_clock);
    cfg[p] <= '{1'b1, thr, rec, dly, cs, ds};
    set_temp(p, near);
    cyc(3);
    `CHK("near alert", 5'h00, alert | fault)
    set_temp(p, trip);
    cyc(2);
    `CHK("alert", (dly == 8'h00) ? 5'h00 : 5'h01 << p, alert)
    `CHK("early fault", (dly == 8'h00), fault[p])
    wait_sig(p, 1'b1, (dly + 2) * TICK);
    cyc(2);
    `CHK("alert cleared", 5'h00, alert)
    `CHK("switches", {cs, ds}, sw_off)
    set_temp(p, rec);
    cyc(5);
    `CHK("held fault", 1'b1, fault[p])
    wait_sig(p, 1'b0, 4 * TICK);
    cyc(2);
    `CHK("switches back", 2'b00, sw_off)
    @(posedge i_clock);
    cfg[p].enable <= 1'b0;
    set_temp(p, 9'h019);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_arst_n <= 1'b1;
    cyc(2);
    @(posedge i_clock);
    cfg[0] <= '{1'b1, 9'h050, 9'h046, 8'h02, 1'b1, 1'b0};
    sensor_temp[2] <= 9'h078;
    sensor_temp[1] <= 9'h05A;
    sensor_enable <= 4'hD;
    cyc(3);
    `CHK("fet max", 5'h00, alert)
    @(posedge i_clock);
    sensor_enable <= 4'hF;
    cyc(3);
    `CHK("fet alert", 5'h01, alert)
    set_temp(0, 9'h019);
    cyc(2);
    `CHK("alert drop", 5'h00, alert | fault)
    @(posedge i_clock);
    sensor_temp[2] <= 9'h019;
    run_prot(0, 9'h096, 9'h095, 9'h096, 9'h08C, 8'h02, 1'b1, 1'b0);
    run_prot(1, 9'h078, 9'h077, 9'h078, 9'h064, 8'h03, 1'b0, 1'b1);
    run_prot(2, 9'h1D8, 9'h1D9, 9'h1D8, 9'h1E2, 8'h02, 1'b1, 1'b0);
    run_prot(3, 9'h000, 9'h001, 9'h000, 9'h00A, 8'h00, 1'b0, 1'b1);
    run_prot(4, 9'h00A, 9'h00B, 9'h005, 9'h014, 8'h02, 1'b1, 1'b1);
    // no autonomous control: die fault stands and both switches stay on
    @(posedge i_clock);
    auto_fet <= 1'b0;
    auto_recover <= 1'b0;
    cfg[1] <= '{1'b1, 9'h078, 9'h064, 8'h00, 1'b1, 1'b1};
    set_temp(1, 9'h078);
    cyc(3);
    `CHK("manual fault", 1'b1, fault[1])
    `CHK("manual switches", 2'b00, sw_off)
    set_temp(1, 9'h064);
    cyc(5 * TICK);
    `CHK("no auto recovery", 1'b1, fault[1])
    `CHK("manual switches held", 2'b00, sw_off)
    @(posedge i_clock);
    cfg[1].enable <= 1'b0;
    auto_fet <= 1'b1;
    auto_recover <= 1'b1;
    set_temp(1, 9'h019);
    cyc(6 * TICK);
    `CHK("guard off", 1'b0, host_fault)
    @(posedge i_clock);
    wd_cfg <= '{1'b1, 16'h0002, 1'b0, 1'b1, `TPROT_REG_KEEP, 4'h2};
    talk <= 1'b1;
    cyc(6 * TICK);
    `CHK("talking", 1'b0, host_fault)
    for (int i = 0; i < 3; i++) begin
      opt = (i == 0) ? `TPROT_REG_KEEP : (i == 1) ? `TPROT_REG_TOGGLE : `TPROT_REG_OFF;
      @(posedge i_clock);
      wd_cfg.reg_option <= opt;
      talk <= 1'b0;
      ldo_two <= 1'b1;
      cyc(5);
      `CHK("silence early", 1'b0, host_fault)
      wait_sig(5, 1'b1, 4 * TICK);
      cyc(3);
      `CHK("no alert", 5'h00, alert)
      `CHK("guard switch", 2'b01, sw_off)
      `CHK("ldo at fault", (opt == `TPROT_REG_KEEP) ? 2'b11 : 2'b00, ldo)
      @(posedge i_clock);
      ldo_two <= 1'b0;
      cyc(5 * TICK);
      `CHK("ldo later", (opt == `TPROT_REG_OFF) ? 2'b00 : 2'b10, ldo)
      @(posedge i_clock);
      talk <= 1'b1;
      wait_sig(5, 1'b0, 20);
    end
    summarize();
  end
endmodule // testbench
